// ===== common/cmd_pkg.sv
// constants and register map of the codec mute / de-emphasis control block
package cmd_pkg;
	// sample path
	localparam int          SAMPLE_W      = 24;
	localparam int          NUM_DAC       = 4;
	localparam int          NUM_CH        = 8;
	// soft-mute decay: a shift of 6 gives a time constant of 64 samples
	localparam int          DECAY_SHIFT   = 6;
	localparam logic [10:0] ZERO_DET_SAMP = 11'h400;
	// register indices and byte addresses (index times four)
	localparam logic [7:0]  IDX_DEEMPH    = 8'h11;
	localparam logic [7:0]  IDX_POLARITY  = 8'h12;
	localparam logic [7:0]  IDX_DAC_MUTE  = 8'h13;
	localparam logic [7:0]  IDX_ADC_CTRL  = 8'h1d;
	localparam logic [7:0]  ADDR_DEEMPH   = {IDX_DEEMPH[5:0], 2'b00};
	localparam logic [7:0]  ADDR_POLARITY = {IDX_POLARITY[5:0], 2'b00};
	localparam logic [7:0]  ADDR_DAC_MUTE = {IDX_DAC_MUTE[5:0], 2'b00};
	localparam logic [7:0]  ADDR_ADC_CTRL = {IDX_ADC_CTRL[5:0], 2'b00};
	localparam logic [7:0]  ADDR_AUX      = 8'h80;
	localparam logic [7:0]  ADDR_STATUS   = 8'h84;
	// field positions
	localparam int          POS_GLOBAL    = 4;
	localparam int          POS_PIN_ALL   = 7;
	localparam int          POS_HPF_BYP   = 4;
	localparam int          POS_OSR_HALF  = 3;
	localparam int          POS_ADC_BOTH  = 2;
	localparam int          POS_ADC_R     = 1;
	localparam int          POS_ADC_L     = 0;
	localparam int          POS_ZD_OPT    = 2;
	// reset values
	localparam logic [3:0]  RST_PER_DAC   = 4'h0;
	localparam logic [7:0]  RST_PHASE     = 8'hff;
	localparam logic        RST_BIT       = 1'b0;
	localparam logic [1:0]  RST_ZF_SEL    = 2'h0;
	// bus responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// adc oversampling codes
	typedef enum logic [1:0] {
		CMD_OSR_128 = 2'h0,
		CMD_OSR_64  = 2'h1,
		CMD_OSR_32  = 2'h2
	} cmd_osr_e;
endpackage : cmd_pkg

// ===== src/cmd_top.sv
// codec mute, de-emphasis, phase and adc filter control with axi4-lite
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - per-dac soft-mute bits, reset zero
// - master soft-mute bit mutes all dacs
// - mute pin decodes to selected dac or all
// - muted output decays toward midpoint, 64 samples
// - all muted 1024 samples plus option: full mute
// - release resumes from current sample immediately
// - other mutes force midpoint at once
// - per-dac de-emphasis enable bits, reset zero
// - global de-emphasis bit enables all dacs
// - phase bit one passes, zero inverts
// - phase bits ordered dac1 left upward
// - high-pass active unless bypass bit set
// - osr 128fs, 64fs with low mclk ratio
// - halve bit halves the adc oversampling rate
// - adc left and right mute bits
// - adc mute-both bit mutes both channels
// - soft-mute sits at interpolation filter input
module cmd_top (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic [2:0]                   s_axi_awprot,
	input  wire logic                         s_axi_awvalid,
	output var  logic                         s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output var  logic                         s_axi_wready,
	output var  logic [1:0]                   s_axi_bresp,
	output var  logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic [2:0]                   s_axi_arprot,
	input  wire logic                         s_axi_arvalid,
	output var  logic                         s_axi_arready,
	output var  logic [31:0]                  s_axi_rdata,
	output var  logic [1:0]                   s_axi_rresp,
	output var  logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         mute_pin,
	input  wire logic                         mclk_ratio_low,
	input  wire logic [3:0]                   analog_mute_req,
	input  wire logic                         sample_strobe,
	input  wire logic [8*24-1:0]              dac_in,
	output var  logic [8*24-1:0]              dac_out,
	output var  logic                         dac_out_strobe,
	output var  logic [3:0]                   dac_deemph_en,
	output var  logic [3:0]                   dac_soft_mute,
	output var  logic [3:0]                   dac_analog_mute,
	output var  logic                         adc_highpass_en,
	output var  logic                         adc_mute_l,
	output var  logic                         adc_mute_r,
	output var  logic [1:0]                   adc_osr
);

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [3:0]  per_dac_deemph_enable;
	logic        global_deemph_enable;
	logic [7:0]  output_phase;
	logic [3:0]  per_dac_soft_mute;
	logic        global_dac_soft_mute;
	logic        mute_pin_decode_all;
	logic        adc_highpass_bypass;
	logic        adc_oversample_halve;
	logic        adc_both_mute;
	logic        adc_left_mute;
	logic        adc_right_mute;
	logic [1:0]  zero_flag_select;
	logic        zero_detect_mute_option;

	// bus state
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        aw_full;
	logic        w_full;
	logic        do_write;
	logic        wr_hit;
	logic [31:0] next_rdata;
	logic        rd_hit;

	// mute state
	logic        pin_sync1;
	logic        pin_sync2;
	logic [3:0]  pin_req;
	logic [3:0]  eff_mute;
	logic [10:0] all_mute_cnt;
	logic        full_mute;

	assign do_write = aw_full && w_full && !s_axi_bvalid;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken in either order,
	// each ready drops on its handshake and returns after the response

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= cmd_pkg::RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			wr_addr       <= 8'h00;
			wr_data       <= 32'h00000000;
			wr_strb       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr       <= s_axi_awaddr;
				aw_full       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
				w_full       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? cmd_pkg::RESP_OKAY
					: cmd_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// writable addresses; the status word is read-only
	always_comb
	begin
		case (wr_addr)
			cmd_pkg::ADDR_DEEMPH,
			cmd_pkg::ADDR_POLARITY,
			cmd_pkg::ADDR_DAC_MUTE,
			cmd_pkg::ADDR_ADC_CTRL,
			cmd_pkg::ADDR_AUX:  wr_hit = 1'b1;
			default:            wr_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// control registers; only byte lane 0 holds stored bits

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			per_dac_deemph_enable   <= cmd_pkg::RST_PER_DAC;
			global_deemph_enable    <= cmd_pkg::RST_BIT;
			output_phase            <= cmd_pkg::RST_PHASE;
			per_dac_soft_mute       <= cmd_pkg::RST_PER_DAC;
			global_dac_soft_mute    <= cmd_pkg::RST_BIT;
			mute_pin_decode_all     <= cmd_pkg::RST_BIT;
			adc_highpass_bypass     <= cmd_pkg::RST_BIT;
			adc_oversample_halve    <= cmd_pkg::RST_BIT;
			adc_both_mute           <= cmd_pkg::RST_BIT;
			adc_left_mute           <= cmd_pkg::RST_BIT;
			adc_right_mute          <= cmd_pkg::RST_BIT;
			zero_flag_select        <= cmd_pkg::RST_ZF_SEL;
			zero_detect_mute_option <= cmd_pkg::RST_BIT;
		end
		else if (do_write && wr_strb[0])
		begin
			case (wr_addr)
				cmd_pkg::ADDR_DEEMPH:
				begin
					per_dac_deemph_enable <= wr_data[3:0];
					global_deemph_enable  <= wr_data[cmd_pkg::POS_GLOBAL];
				end
				cmd_pkg::ADDR_POLARITY:
				begin
					output_phase <= wr_data[7:0];
				end
				cmd_pkg::ADDR_DAC_MUTE:
				begin
					per_dac_soft_mute    <= wr_data[3:0];
					global_dac_soft_mute <= wr_data[cmd_pkg::POS_GLOBAL];
					mute_pin_decode_all  <= wr_data[cmd_pkg::POS_PIN_ALL];
				end
				cmd_pkg::ADDR_ADC_CTRL:
				begin
					adc_highpass_bypass  <= wr_data[cmd_pkg::POS_HPF_BYP];
					adc_oversample_halve <= wr_data[cmd_pkg::POS_OSR_HALF];
					adc_both_mute        <= wr_data[cmd_pkg::POS_ADC_BOTH];
					adc_right_mute       <= wr_data[cmd_pkg::POS_ADC_R];
					adc_left_mute        <= wr_data[cmd_pkg::POS_ADC_L];
				end
				cmd_pkg::ADDR_AUX:
				begin
					zero_flag_select        <= wr_data[1:0];
					zero_detect_mute_option <= wr_data[cmd_pkg::POS_ZD_OPT];
				end
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read decode; unused bits read as zero

	always_comb
	begin
		next_rdata = 32'h00000000;
		rd_hit     = 1'b1;
		case (s_axi_araddr)
			cmd_pkg::ADDR_DEEMPH:
			begin
				next_rdata[3:0]                 = per_dac_deemph_enable;
				next_rdata[cmd_pkg::POS_GLOBAL] = global_deemph_enable;
			end
			cmd_pkg::ADDR_POLARITY:
			begin
				next_rdata[7:0] = output_phase;
			end
			cmd_pkg::ADDR_DAC_MUTE:
			begin
				next_rdata[3:0]                  = per_dac_soft_mute;
				next_rdata[cmd_pkg::POS_GLOBAL]  = global_dac_soft_mute;
				next_rdata[cmd_pkg::POS_PIN_ALL] = mute_pin_decode_all;
			end
			cmd_pkg::ADDR_ADC_CTRL:
			begin
				next_rdata[cmd_pkg::POS_HPF_BYP]  = adc_highpass_bypass;
				next_rdata[cmd_pkg::POS_OSR_HALF] = adc_oversample_halve;
				next_rdata[cmd_pkg::POS_ADC_BOTH] = adc_both_mute;
				next_rdata[cmd_pkg::POS_ADC_R]    = adc_right_mute;
				next_rdata[cmd_pkg::POS_ADC_L]    = adc_left_mute;
			end
			cmd_pkg::ADDR_AUX:
			begin
				next_rdata[1:0]                 = zero_flag_select;
				next_rdata[cmd_pkg::POS_ZD_OPT] = zero_detect_mute_option;
			end
			cmd_pkg::ADDR_STATUS:
			begin
				// live state: effective mutes, full mute, osr code
				next_rdata[3:0] = eff_mute;
				next_rdata[4]   = full_mute;
				next_rdata[5]   = pin_sync2;
				next_rdata[9:8] = adc_osr;
			end
			default:
			begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// read channel: one read in flight, answer the cycle after address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= cmd_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= rd_hit ? cmd_pkg::RESP_OKAY
				: cmd_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mute pin: asynchronous, so two flops before any decode

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
		end
		else
		begin
			pin_sync1 <= mute_pin;
			pin_sync2 <= pin_sync1;
		end
	end

	// pin decode and or of the three mute sources
	always_comb
	begin
		pin_req = 4'h0;
		if (pin_sync2)
		begin
			if (mute_pin_decode_all)
				pin_req = 4'hf;
			else
				pin_req[zero_flag_select] = 1'b1;
		end
		eff_mute = per_dac_soft_mute
			| {4{global_dac_soft_mute}}
			| pin_req;
	end

	////////////////////////////////////////////////////////////////////////
	// zero-detect: all dacs soft-muted for enough input samples
	// the counter saturates so a long mute never wraps back to unmuted

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			all_mute_cnt <= 11'h000;
			full_mute    <= 1'b0;
		end
		else
		begin
			if (eff_mute != 4'hf)
				all_mute_cnt <= 11'h000;
			else if (sample_strobe
				&& all_mute_cnt != cmd_pkg::ZERO_DET_SAMP)
				all_mute_cnt <= all_mute_cnt + 11'h001;
			full_mute <= zero_detect_mute_option
				&& eff_mute == 4'hf
				&& all_mute_cnt == cmd_pkg::ZERO_DET_SAMP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-dac flags and adc controls, registered onto the pins

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dac_deemph_en   <= 4'h0;
			dac_soft_mute   <= 4'h0;
			dac_analog_mute <= 4'h0;
			adc_highpass_en <= 1'b1;
			adc_mute_l      <= 1'b0;
			adc_mute_r      <= 1'b0;
			adc_osr         <= cmd_pkg::CMD_OSR_128;
		end
		else
		begin
			dac_deemph_en   <= per_dac_deemph_enable
				| {4{global_deemph_enable}};
			dac_soft_mute   <= eff_mute;
			dac_analog_mute <= analog_mute_req | {4{full_mute}};
			adc_highpass_en <= !adc_highpass_bypass;
			adc_mute_l      <= adc_left_mute || adc_both_mute;
			adc_mute_r      <= adc_right_mute || adc_both_mute;
			case ({mclk_ratio_low, adc_oversample_halve})
				2'h0:    adc_osr <= cmd_pkg::CMD_OSR_128;
				2'h1:    adc_osr <= cmd_pkg::CMD_OSR_64;
				2'h2:    adc_osr <= cmd_pkg::CMD_OSR_64;
				default: adc_osr <= cmd_pkg::CMD_OSR_32;
			endcase
		end
	end

	// output strobe follows the input strobe by one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dac_out_strobe <= 1'b0;
		else
			dac_out_strobe <= sample_strobe;
	end

	////////////////////////////////////////////////////////////////////////
	// sample path per channel: soft-mute decay, phase, analog mute
	// this feeds the interpolation filters, so soft-mute acts before them

	genvar ch;
	generate
		for (ch = 0; ch < cmd_pkg::NUM_CH; ch++)
		begin : g_ch
			logic signed [23:0] in_s;
			logic signed [23:0] level;
			logic signed [23:0] step;
			logic signed [23:0] muted_v;
			logic signed [23:0] next_out;
			logic               sm;
			logic               am;

			assign in_s = dac_in[ch*24 +: 24];
			assign step = level >>> cmd_pkg::DECAY_SHIFT;
			assign sm   = eff_mute[ch/2];              // pairs l, r
			assign am   = analog_mute_req[ch/2] || full_mute;
			// small positive levels would never shrink with a plain shift
			assign muted_v = (step == 24'sh000000) ? 24'sh000000
				: level - step;

			// level tracks the input while unmuted, decays while muted
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					level <= 24'sh000000;
				else if (sample_strobe)
					level <= sm ? muted_v : in_s;
			end

			// phase after mute; negating full scale saturates
			always_comb
			begin
				next_out = sm ? muted_v : in_s;
				if (!output_phase[ch])
				begin
					if (next_out == 24'sh800000)
						next_out = 24'sh7fffff;
					else
						next_out = -next_out;
				end
			end

			// analog mute acts at once, without waiting for a sample
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					dac_out[ch*24 +: 24] <= 24'h000000;
				else if (am)
					dac_out[ch*24 +: 24] <= 24'h000000;
				else if (sample_strobe)
					dac_out[ch*24 +: 24] <= next_out;
			end
		end
	endgenerate

endmodule : cmd_top

`default_nettype wire

// ===== tb/cmd_checker.sv
// concurrent checks on the bus handshake and sample path ports
`timescale 1ns/1ps
`default_nettype none
module cmd_checker (
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         s_axi_awvalid,
	input wire logic         s_axi_awready,
	input wire logic         s_axi_wvalid,
	input wire logic         s_axi_wready,
	input wire logic [1:0]   s_axi_bresp,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_bready,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	input wire logic         mclk_ratio_low,
	input wire logic [3:0]   analog_mute_req,
	input wire logic         sample_strobe,
	input wire logic [191:0] dac_out,
	input wire logic         dac_out_strobe,
	input wire logic [3:0]   dac_analog_mute,
	input wire logic [1:0]   adc_osr
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// helper: a dac muted for two edges running must show zero samples
	logic [3:0] prev_am;
	logic       zero_bad;
	always_ff @(posedge aclk)
	begin
		prev_am <= aresetn ? dac_analog_mute : 4'h0;
	end
	always_comb
	begin
		zero_bad = 1'b0;
		for (int n = 0; n < 4; n++)
			zero_bad = zero_bad | (prev_am[n] & dac_analog_mute[n]
				& (dac_out[48*n +: 48] != 48'h0));
	end
	////////////////////////////////////////////////////////////////////////
	// the write lands one edge after both are taken, bvalid rises on that same edge
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_write_refuse: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_strobe_follow: assert property ($past(aresetn)
		|-> dac_out_strobe == $past(sample_strobe))
		else $error("output strobe misplaced");
	chk_analog_req: assert property (analog_mute_req != 4'h0
		|=> (dac_analog_mute & $past(analog_mute_req))
		== $past(analog_mute_req))
		else $error("abrupt mute not applied");
	chk_analog_zero: assert property (!zero_bad)
		else $error("abrupt mute output not midpoint");
	chk_out_hold: assert property ($past(aresetn)
		&& !$past(sample_strobe)
		&& dac_analog_mute == 4'h0 && $past(dac_analog_mute) == 4'h0
		|-> $stable(dac_out))
		else $error("output moved without sample");
	chk_osr_low: assert property ($past(aresetn)
		&& $past(mclk_ratio_low)
		|-> adc_osr != cmd_pkg::CMD_OSR_128)
		else $error("oversampling too high for low ratio");
	chk_osr_high: assert property ($past(aresetn)
		&& !$past(mclk_ratio_low)
		|-> adc_osr != cmd_pkg::CMD_OSR_32)
		else $error("oversampling too low for high ratio");
endmodule : cmd_checker
bind cmd_top cmd_checker i_cmd_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.mclk_ratio_low(mclk_ratio_low), .analog_mute_req(analog_mute_req),
	.sample_strobe(sample_strobe), .dac_out(dac_out),
	.dac_out_strobe(dac_out_strobe), .dac_analog_mute(dac_analog_mute),
	.adc_osr(adc_osr));
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the codec mute and filter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic         aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]   aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0]  w_d = 32'h0, r_d;
	logic         aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
	logic         ar_v = 1'b0, r_rdy = 1'b0;
	logic         aw_rdy, w_rdy, b_v, ar_rdy, r_v, out_stb, hpf, aml, amr;
	logic [1:0]   b_resp, r_resp, osr;
	logic         pin = 1'b0, mlow = 1'b0, stb = 1'b0, slow = 1'b0;
	logic [3:0]   amreq = 4'h0, deemph, smute, amute;
	logic [191:0] din = 192'h0, dout, x, m;
	logic [31:0]  seed = 32'h7099, v, d, cyc = 32'h0;
	logic [23:0]  l0, l1;
	logic [1:0]   r;
	int           err_total = 0, num_checks = 0, i;
	cmd_top i_cmd_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v),
		.s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a),
		.s_axi_arprot(3'h0), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
		.s_axi_rready(r_rdy), .mute_pin(pin), .mclk_ratio_low(mlow),
		.analog_mute_req(amreq), .sample_strobe(stb), .dac_in(din),
		.dac_out(dout), .dac_out_strobe(out_stb), .dac_deemph_en(deemph),
		.dac_soft_mute(smute), .dac_analog_mute(amute),
		.adc_highpass_en(hpf), .adc_mute_l(aml), .adc_mute_r(amr),
		.adc_osr(osr));
	////////////////////////////////////////////////////////////////////////
	// clock and a cycle ceiling far above the few thousand cycles used
	always #12.5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'd20000)
		begin
			err_total++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// expectation helpers; xorshift keeps every run identical
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [191:0] rnd_smp();
		return {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
	endfunction : rnd_smp
	// negating full scale would overflow, so it clips to the maximum
	function automatic logic [191:0] exp_out(input logic [191:0] s,
		input logic [7:0] p);
		logic [191:0] o;
		logic [23:0]  e;
		for (int k = 0; k < 8; k++)
		begin
			e = s[24*k +: 24];
			if (!p[k])
				e = (e == 24'h800000) ? 24'h7fffff : -e;
			o[24*k +: 24] = e;
		end
		return o;
	endfunction : exp_out
	function automatic logic [23:0] dec(input logic [23:0] l);
		logic [23:0] s;
		s = $signed(l) >>> 6;
		return (s == 24'h0) ? 24'h0 : l - s;
	endfunction : dec
	////////////////////////////////////////////////////////////////////////
	// comparison, reporting and bus tasks
	task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [31:0] dw);
		logic got;
		@(posedge aclk);
		aw_a <= a;
		w_d <= dw;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= !slow;
		got = 1'b0;
		while (!got)
		begin
			@(posedge aclk);
			if (aw_v && aw_rdy)
				aw_v <= 1'b0;
			if (w_v && w_rdy)
				w_v <= 1'b0;
			if (b_v && b_rdy)
			begin
				r = b_resp;
				b_rdy <= 1'b0;
				got = 1'b1;
			end
			// a slow master only answers once the response is seen
			else if (b_v)
				b_rdy <= 1'b1;
		end
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic got;
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= !slow;
		got = 1'b0;
		while (!got)
		begin
			@(posedge aclk);
			if (ar_v && ar_rdy)
				ar_v <= 1'b0;
			if (r_v && r_rdy)
			begin
				chk(r_d, e);
				chk(r_resp, er);
				r_rdy <= 1'b0;
				got = 1'b1;
			end
			else if (r_v)
				r_rdy <= 1'b1;
		end
	endtask : rchk
	// a run of n back-to-back samples, then one edge to read the result
	task automatic samp(input int n, input logic [191:0] s);
		@(posedge aclk);
		stb <= 1'b1;
		din <= s;
		repeat (n) @(posedge aclk);
		stb <= 1'b0;
		@(posedge aclk);
	endtask : samp
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		settle(6);
		aresetn <= 1'b1;
		rchk(cmd_pkg::ADDR_DEEMPH, 32'h0, cmd_pkg::RESP_OKAY);
		rchk(cmd_pkg::ADDR_POLARITY, 32'hff, cmd_pkg::RESP_OKAY);
		rchk(cmd_pkg::ADDR_DAC_MUTE, 32'h0, cmd_pkg::RESP_OKAY);
		rchk(cmd_pkg::ADDR_ADC_CTRL, 32'h0, cmd_pkg::RESP_OKAY);
		chk(hpf, 1'b1);
		rchk(8'h00, 32'h0, cmd_pkg::RESP_SLVERR);
		wr(cmd_pkg::ADDR_STATUS, 32'h1);
		chk(r, cmd_pkg::RESP_SLVERR);
		$display("test reset and map finished");
		for (i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 32'h10 : rnd() & 32'h1f;
			// every other pass holds off bready and rready one cycle
			slow = i[0];
			wr(cmd_pkg::ADDR_DEEMPH, v);
			rchk(cmd_pkg::ADDR_DEEMPH, v, cmd_pkg::RESP_OKAY);
			chk(deemph, v[4] ? 4'hf : v[3:0]);
		end
		slow = 1'b0;
		$display("test de-emphasis finished");
		for (i = 0; i < 64; i++)
		begin
			mlow <= i[5];
			wr(cmd_pkg::ADDR_ADC_CTRL, i & 32'h1f);
			settle(3);
			chk(hpf, !i[4]);
			chk({aml, amr}, {i[0] | i[2], i[1] | i[2]});
			chk(osr, {1'b0, i[5]} + {1'b0, i[3]});
		end
		$display("test adc controls finished");
		for (i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 32'h0 : rnd() & 32'hff;
			wr(cmd_pkg::ADDR_POLARITY, v);
			rchk(cmd_pkg::ADDR_POLARITY, v, cmd_pkg::RESP_OKAY);
			x = rnd_smp();
			x[23:0] = 24'h800000;
			samp(1, x);
			chk(dout, exp_out(x, v[7:0]));
		end
		wr(cmd_pkg::ADDR_POLARITY, 32'hff);
		$display("test phase finished");
		for (i = 0; i < 12; i++)
		begin
			v = rnd() & 32'h1f;
			wr(cmd_pkg::ADDR_DAC_MUTE, v);
			settle(3);
			chk(smute, v[4] ? 4'hf : v[3:0]);
		end
		// zero-flag select steers the pin to one dac; last pass decodes all
		for (i = 0; i < 5; i++)
		begin
			wr(cmd_pkg::ADDR_AUX, i & 32'h3);
			wr(cmd_pkg::ADDR_DAC_MUTE, (i == 4) ? 32'h80 : 32'h0);
			pin <= 1'b1;
			settle(5);
			chk(smute, (i == 4) ? 4'hf : 4'h1 << i);
			pin <= 1'b0;
			settle(5);
			chk(smute, 4'h0);
		end
		$display("test mute controls finished");
		wr(cmd_pkg::ADDR_DAC_MUTE, 32'h0);
		x = rnd_smp();
		samp(1, x);
		l0 = x[23:0];
		l1 = x[47:24];
		wr(cmd_pkg::ADDR_DAC_MUTE, 32'h1);
		settle(3);
		for (i = 0; i < 70; i++)
		begin
			x = rnd_smp();
			l0 = dec(l0);
			l1 = dec(l1);
			samp(1, x);
			chk(dout[47:0], {l1, l0});
			chk(dout[191:48], x[191:48]);
		end
		wr(cmd_pkg::ADDR_DAC_MUTE, 32'h0);
		settle(3);
		x = rnd_smp();
		samp(1, x);
		chk(dout, x);
		$display("test decay finished");
		// one strobe short of the count must not yet silence the dacs
		wr(cmd_pkg::ADDR_AUX, 32'h4);
		wr(cmd_pkg::ADDR_DAC_MUTE, 32'h10);
		settle(3);
		samp(1023, x);
		settle(3);
		chk(amute, 4'h0);
		samp(1, x);
		settle(3);
		chk(amute, 4'hf);
		chk(dout, 192'h0);
		// status: all four muted, full mute, pin idle, osr code 32fs
		rchk(cmd_pkg::ADDR_STATUS, 32'h21f, cmd_pkg::RESP_OKAY);
		wr(cmd_pkg::ADDR_DAC_MUTE, 32'h0);
		wr(cmd_pkg::ADDR_AUX, 32'h0);
		settle(3);
		samp(1, x);
		chk(amute, 4'h0);
		chk(dout, x);
		for (i = 0; i < 4; i++)
		begin
			amreq <= 4'h1 << i;
			settle(3);
			m = x;
			m[48*i +: 48] = 48'h0;
			chk(amute, 4'h1 << i);
			chk(dout, m);
			amreq <= 4'h0;
			samp(1, x);
			chk(dout, x);
		end
		$display("test full and abrupt mute finished");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
